/* File: hw/pip_pkg.sv */
// Package with constants, commands and carriers of the interrupt block.
package pip_pkg;

	// ************************************************************
	// Sizes and fixed level assignments
	// ************************************************************
	localparam int LEVELS = 16;
	localparam int SUBS = 64;
	localparam int VA_W = 8;
	localparam int BLK_W = 9;
	localparam int BLK_SHIFT = 7;
	localparam logic [3:0] LVL_POWER = 4'h0;
	localparam logic [3:0] LVL_PROTECT = 4'h2;
	localparam logic [3:0] LVL_UNIMPL = 4'h3;
	localparam logic [3:0] LVL_PL_XFER = 4'h4;
	localparam logic [3:0] LVL_PL_END = 4'h5;
	localparam logic [3:0] LVL_RTC = 4'h6;
	localparam logic [3:0] LVL_CONSOLE = 4'he;

	// ************************************************************
	// Vector memory layout and reset values
	// ************************************************************
	localparam logic [VA_W-1:0] SUB_BASE = 8'h20;
	localparam logic [VA_W-1:0] SUB_SPAN = 8'h40;
	localparam logic [BLK_W-1:0] BOUND_RESET = 9'h000;
	localparam logic [BLK_W-1:0] COMMON_RESET = 9'h1ff;

	// ************************************************************
	// Real-time clock timing
	// ************************************************************
	localparam longint CLK_HZ = 250_000_000;
	localparam longint RTC_HZ = 200;
	localparam int RTC_CYCLES = int'(CLK_HZ / RTC_HZ);
	localparam int RTC_W = 21;

	// ************************************************************
	// Program command port
	// ************************************************************
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_SET_EN = 4'h1,
		OP_CLR_EN = 4'h2,
		OP_SET_REQ = 4'h3,
		OP_CLR_REQ = 4'h4,
		OP_SET_DEFER = 4'h5,
		OP_CLR_DEFER = 4'h6,
		OP_RETURN = 4'h7,
		OP_CONNECT = 4'h8,
		OP_DISCONNECT = 4'h9,
		OP_LOAD_UPPER = 4'ha,
		OP_LOAD_LOWER = 4'hb,
		OP_LOAD_COMMON = 4'hc,
		OP_WRITE_VEC = 4'hd
	} cmd_op_t;

	typedef struct packed {
		logic valid;
		cmd_op_t op;
		logic [3:0] level;
		logic [VA_W-1:0] addr;
		logic [15:0] data;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic branch;
		logic [15:0] addr;
	} acc_t;

	typedef struct packed {
		logic valid;
		logic [3:0] level;
		logic sub_valid;
		logic [5:0] sub;
		logic [15:0] entry;
	} vec_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAVE = 2'b01,
		ST_READ = 2'b10,
		ST_CAPT = 2'b11
	} state_t;

endpackage : pip_pkg

/* File: hw/priority_interrupt_protect.sv */
// Priority interrupt system with memory protect and privileged traps.
//
// Operation
// - Seven standard levels, structure sized for sixteen hardware levels.
// - Two standard levels each carry sixty-four prioritised identified sub-levels.
// - Every level owns an entry word and a return word in memory.
// - Highest pending request saves return address and vectors to entry.
// - Each level has a program enable; disabled levels are never serviced.
// - Program can raise any level's request, handled like a hardware one.
// - Program can defer chosen levels to the low end of the queue.
// - Uninstalled optional instruction raises the unimplemented-instruction level.
// - Monitor-call instruction always raises the unimplemented-instruction level.
// - Party-line devices drive their line only while program-connected.
// - Each party-line sub-level vectors through its own entry word.
// - Real-time clock requests level six at 200 Hz while enabled.
// - Console pushbutton requests level E.
// - Power turning on or off requests level zero.
// - Keyswitch enables protection and disables all panel switches but data.
// - Upper and lower bounds are program-loaded in 128-word units.
// - Write or branch outside bounds from inside is aborted, traps level 2.
// - Program-loaded common boundary; common area up to top stays open.
// - Privileged instruction from a protected program is refused and traps level 2.
`timescale 1ns/1ps
module priority_interrupt_protect #(
	parameter int RTC_DIV = pip_pkg::RTC_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire pip_pkg::cmd_t cmd,
	output logic cmd_ready,
	output logic cmd_refused,
	input wire logic cpu_boundary,
	input wire logic [15:0] cpu_pc,
	input wire logic unimpl_instr,
	input wire logic monitor_call,
	input wire logic priv_instr,
	input wire logic power_event,
	input wire logic console_btn,
	input wire logic keyswitch,
	input wire pip_pkg::acc_t mem_acc,
	output logic access_abort,
	output logic priv_abort,
	input wire logic [pip_pkg::SUBS-1:0] pl_xfer_line,
	input wire logic [pip_pkg::SUBS-1:0] pl_end_line,
	output logic [pip_pkg::SUBS-1:0] xfer_connect,
	output logic [pip_pkg::SUBS-1:0] end_connect,
	output pip_pkg::vec_t vec,
	output logic [pip_pkg::LEVELS-1:0] enable_mask,
	output logic [pip_pkg::LEVELS-1:0] request_mask,
	output logic [pip_pkg::LEVELS-1:0] active_mask,
	output logic [pip_pkg::LEVELS-1:0] defer_mask,
	output logic panel_ctrl_ok
);

	// ************************************************************
	// Helper functions
	// ************************************************************

	// First set bit from the low end; bit 6 of the result says found.
	function automatic logic [6:0] first_set(input logic [63:0] v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = 63; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 6'(i)};
			end
		end
		return r;
	endfunction : first_set

	// One-hot mask of a level number.
	function automatic logic [15:0] lvl_bit(input logic [3:0] l);
		return 16'h0001 << l;
	endfunction : lvl_bit

	// Block number is within the program's own bounds.
	function automatic logic in_bounds(input logic [8:0] b,
			input logic [8:0] lo, input logic [8:0] hi);
		return (b >= lo) && (b <= hi);
	endfunction : in_bounds

	// ************************************************************
	// State
	// ************************************************************
	pip_pkg::state_t st_q;
	logic [15:0] en_q, req_q, act_q, defer_q;
	logic [63:0] conn_x_q, conn_e_q;
	logic [8:0] upper_q, lower_q, common_q;
	logic [pip_pkg::RTC_W-1:0] rtc_q;
	logic btn_q, panel_q;
	logic [3:0] lvl_q;
	logic subv_q, pl_end_q;
	logic [5:0] sub_q;
	logic [15:0] ret_q;
	pip_pkg::vec_t vec_q;

	logic [15:0] pend, ready_nd, ready_df, set_v, clr_v, act_set, act_clr;
	logic [63:0] x_hits, e_hits;
	logic [6:0] cur, best_nd, best_df, x_first, e_first;
	logic take, take_df, cmd_go, rtc_tick;
	logic [3:0] take_lvl;
	logic prog_inside, tgt_prot;
	logic [8:0] pc_blk, tgt_blk;
	logic mem_we;
	logic [pip_pkg::VA_W-1:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata;

	// ************************************************************
	// Protection checks
	// ************************************************************

	// Blocks of 128 words are compared, so the low address bits drop out.
	assign pc_blk = cpu_pc[15:pip_pkg::BLK_SHIFT];
	assign tgt_blk = mem_acc.addr[15:pip_pkg::BLK_SHIFT];
	assign prog_inside = keyswitch &&
		in_bounds(pc_blk, lower_q, upper_q);
	// Common area from its boundary to the top of memory stays open.
	assign tgt_prot = !in_bounds(tgt_blk, lower_q, upper_q) &&
		(tgt_blk < common_q);
	assign access_abort = prog_inside && mem_acc.valid &&
		(mem_acc.write || mem_acc.branch) && tgt_prot;
	// Every command on the port is interrupt or machine-state control.
	assign priv_abort = prog_inside && (priv_instr || cmd.valid);
	assign cmd_refused = prog_inside && cmd.valid;

	// Panel controls other than data switches are dead under the key.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			panel_q <= 1'b1;
		end else begin
			panel_q <= !keyswitch;
		end
	end

	// ************************************************************
	// Priority resolution
	// ************************************************************

	// Party lines listen only to devices that the program connected.
	assign x_hits = pl_xfer_line & conn_x_q;
	assign e_hits = pl_end_line & conn_e_q;
	assign x_first = first_set(x_hits);
	assign e_first = first_set(e_hits);

	// A level already in service is not entered again until it returns.
	always_comb begin
		pend = req_q;
		pend[pip_pkg::LVL_PL_XFER] = req_q[pip_pkg::LVL_PL_XFER] | x_first[6];
		pend[pip_pkg::LVL_PL_END] = req_q[pip_pkg::LVL_PL_END] | e_first[6];
		pend = pend & en_q & ~act_q;
	end

	assign ready_nd = pend & ~defer_q;
	assign ready_df = pend & defer_q;
	assign cur = first_set({48'h0, act_q});
	assign best_nd = first_set({48'h0, ready_nd});
	assign best_df = first_set({48'h0, ready_df});

	// Deferred levels wait until no level is active and no undeferred level is ready.
	assign take_df = !best_nd[6] && best_df[6] && !cur[6];
	assign take = (st_q == pip_pkg::ST_IDLE) && cpu_boundary &&
		((best_nd[6] && (!cur[6] || best_nd[5:0] < cur[5:0])) ||
		take_df);
	assign take_lvl = take_df ? best_df[3:0] : best_nd[3:0];

	assign cmd_ready = (st_q == pip_pkg::ST_IDLE) && !take;
	assign cmd_go = cmd.valid && cmd_ready && !cmd_refused;

	// ************************************************************
	// Request sources
	// ************************************************************

	// Free-running divider; a long count, so the period is a parameter.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rtc_q <= '0;
		end else if (rtc_tick) begin
			rtc_q <= '0;
		end else begin
			rtc_q <= rtc_q + 1'b1;
		end
	end
	assign rtc_tick = (rtc_q == pip_pkg::RTC_W'(RTC_DIV - 1));

	// The button is a level, so only its press edge makes a request.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			btn_q <= 1'b0;
		end else begin
			btn_q <= console_btn;
		end
	end

	// Sources and program writes; a set always beats a clear.
	always_comb begin
		set_v = 16'h0000;
		clr_v = 16'h0000;
		if (power_event) begin
			set_v = set_v | lvl_bit(pip_pkg::LVL_POWER);
		end
		if (access_abort || priv_abort) begin
			set_v = set_v | lvl_bit(pip_pkg::LVL_PROTECT);
		end
		if (unimpl_instr) begin
			set_v = set_v | lvl_bit(pip_pkg::LVL_UNIMPL);
		end
		if (monitor_call) begin
			set_v = set_v | lvl_bit(pip_pkg::LVL_UNIMPL);
		end
		if (rtc_tick && en_q[pip_pkg::LVL_RTC]) begin
			set_v = set_v | lvl_bit(pip_pkg::LVL_RTC);
		end
		if (console_btn && !btn_q) begin
			set_v = set_v | lvl_bit(pip_pkg::LVL_CONSOLE);
		end
		if (cmd_go && cmd.op == pip_pkg::OP_SET_REQ) begin
			set_v = set_v | lvl_bit(cmd.level);
		end
		if (cmd_go && cmd.op == pip_pkg::OP_CLR_REQ) begin
			clr_v = clr_v | lvl_bit(cmd.level);
		end
		if (take) begin
			clr_v = clr_v | lvl_bit(take_lvl);
		end
	end

	// Request latches, one per level.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			req_q <= 16'h0000;
		end else begin
			req_q <= (req_q & ~clr_v) | set_v;
		end
	end

	// ************************************************************
	// Program controlled masks and bounds
	// ************************************************************

	// Enable and defer masks.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			en_q <= 16'h0000;
			defer_q <= 16'h0000;
		end else if (cmd_go) begin
			unique case (cmd.op)
				pip_pkg::OP_SET_EN: en_q <= en_q | lvl_bit(cmd.level);
				pip_pkg::OP_CLR_EN: en_q <= en_q & ~lvl_bit(cmd.level);
				pip_pkg::OP_SET_DEFER: defer_q <= defer_q | lvl_bit(cmd.level);
				pip_pkg::OP_CLR_DEFER: defer_q <= defer_q & ~lvl_bit(cmd.level);
				default: ;
			endcase
		end
	end

	// Device connection; the line is picked by the level field.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			conn_x_q <= 64'h0;
			conn_e_q <= 64'h0;
		end else if (cmd_go && (cmd.op == pip_pkg::OP_CONNECT ||
				cmd.op == pip_pkg::OP_DISCONNECT)) begin
			if (cmd.level == pip_pkg::LVL_PL_XFER) begin
				conn_x_q[cmd.data[5:0]] <=
					(cmd.op == pip_pkg::OP_CONNECT);
			end else if (cmd.level == pip_pkg::LVL_PL_END) begin
				conn_e_q[cmd.data[5:0]] <=
					(cmd.op == pip_pkg::OP_CONNECT);
			end
		end
	end

	// Boundary registers take a block number in the low data bits.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			upper_q <= pip_pkg::COMMON_RESET;
			lower_q <= pip_pkg::BOUND_RESET;
			common_q <= pip_pkg::COMMON_RESET;
		end else if (cmd_go) begin
			unique case (cmd.op)
				pip_pkg::OP_LOAD_UPPER: upper_q <= cmd.data[8:0];
				pip_pkg::OP_LOAD_LOWER: lower_q <= cmd.data[8:0];
				pip_pkg::OP_LOAD_COMMON: common_q <= cmd.data[8:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Active levels and context switch
	// ************************************************************

	// Return clears the level now in service; a new take wins over it.
	always_comb begin
		act_set = take ? lvl_bit(take_lvl) : 16'h0000;
		act_clr = 16'h0000;
		if (cmd_go && cmd.op == pip_pkg::OP_RETURN && cur[6]) begin
			act_clr = lvl_bit(cur[3:0]);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			act_q <= 16'h0000;
		end else begin
			act_q <= (act_q & ~act_clr) | act_set;
		end
	end

	// Save, read entry, present vector; one word per memory cycle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= pip_pkg::ST_IDLE;
			lvl_q <= 4'h0;
			subv_q <= 1'b0;
			pl_end_q <= 1'b0;
			sub_q <= 6'h00;
			ret_q <= 16'h0000;
		end else begin
			unique case (st_q)
				pip_pkg::ST_IDLE: begin
					if (take) begin
						st_q <= pip_pkg::ST_SAVE;
						lvl_q <= take_lvl;
						ret_q <= cpu_pc;
						pl_end_q <= (take_lvl == pip_pkg::LVL_PL_END);
						if (take_lvl == pip_pkg::LVL_PL_XFER) begin
							subv_q <= x_first[6];
							sub_q <= x_first[5:0];
						end else if (take_lvl == pip_pkg::LVL_PL_END) begin
							subv_q <= e_first[6];
							sub_q <= e_first[5:0];
						end else begin
							subv_q <= 1'b0;
							sub_q <= 6'h00;
						end
					end
				end
				pip_pkg::ST_SAVE: st_q <= pip_pkg::ST_READ;
				pip_pkg::ST_READ: st_q <= pip_pkg::ST_CAPT;
				pip_pkg::ST_CAPT: st_q <= pip_pkg::ST_IDLE;
			endcase
		end
	end

	// Memory port: return save, entry fetch, or a program vector write.
	always_comb begin
		mem_we = 1'b0;
		mem_addr = {3'b000, lvl_q, 1'b0};
		mem_wdata = ret_q;
		unique case (st_q)
			pip_pkg::ST_SAVE: begin
				mem_we = 1'b1;
				mem_addr = {3'b000, lvl_q, 1'b1};
			end
			pip_pkg::ST_READ: begin
				if (subv_q) begin
					mem_addr = pip_pkg::SUB_BASE + {2'b00, sub_q} +
						(pl_end_q ? pip_pkg::SUB_SPAN : 8'h00);
				end else begin
					mem_addr = {3'b000, lvl_q, 1'b0};
				end
			end
			default: begin
				if (cmd_go && cmd.op == pip_pkg::OP_WRITE_VEC) begin
					mem_we = 1'b1;
					mem_addr = cmd.addr;
					mem_wdata = cmd.data;
				end
			end
		endcase
	end

	vector_ram #(
		.WIDTH(16),
		.DEPTH(256),
		.AW(pip_pkg::VA_W)
	) u_vram (
		.clock(clock),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata_q(mem_rdata)
	);

	// The vector is a one-cycle pulse carrying the entry address.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			vec_q <= '0;
		end else begin
			vec_q.valid <= (st_q == pip_pkg::ST_CAPT);
			if (st_q == pip_pkg::ST_CAPT) begin
				vec_q.level <= lvl_q;
				vec_q.sub_valid <= subv_q;
				vec_q.sub <= sub_q;
				vec_q.entry <= mem_rdata;
			end
		end
	end

	// ************************************************************
	// Status outputs
	// ************************************************************
	assign vec = vec_q;
	assign enable_mask = en_q;
	assign request_mask = req_q;
	assign active_mask = act_q;
	assign defer_mask = defer_q;
	assign xfer_connect = conn_x_q;
	assign end_connect = conn_e_q;
	assign panel_ctrl_ok = panel_q;

endmodule : priority_interrupt_protect

/* File: hw/vector_ram.sv */
// Small word memory that holds entry and return words of all levels.
`timescale 1ns/1ps
module vector_ram #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata_q
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Read first port; read data is always registered.
	always_ff @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_q <= mem[addr];
	end

endmodule : vector_ram

/* File: tb/party_devices.sv */
// Model of the peripheral devices on the two party request lines.
`timescale 1ns/1ps
module party_devices (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ask,
	input wire logic ask_end,
	input wire logic [5:0] ask_dev,
	input wire logic [63:0] xfer_connect,
	input wire logic [63:0] end_connect,
	input wire pip_pkg::vec_t vec,
	output logic [63:0] pl_xfer_line,
	output logic [63:0] pl_end_line
);
	logic [63:0] xfer_q;
	logic [63:0] end_q;
	// A device holds its wish until its own sub-level is vectored.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			xfer_q <= 64'h0;
			end_q <= 64'h0;
		end else begin
			if (vec.valid && vec.sub_valid && vec.level == 4'h4) begin
				xfer_q[vec.sub] <= 1'b0;
			end
			if (vec.valid && vec.sub_valid && vec.level == 4'h5) begin
				end_q[vec.sub] <= 1'b0;
			end
			if (ask && !ask_end) begin
				xfer_q[ask_dev] <= 1'b1;
			end
			if (ask && ask_end) begin
				end_q[ask_dev] <= 1'b1;
			end
		end
	end
	// Unconnected devices leave the line at its pulled-down idle level.
	assign pl_xfer_line = xfer_q & xfer_connect;
	assign pl_end_line = end_q & end_connect;
endmodule : party_devices

/* File: tb/pip_monitor.sv */
// Port checker of the priority interrupt and protect block.
`timescale 1ns/1ps
module pip_monitor (
	input wire logic clock,
	input wire logic rstn,
	input wire pip_pkg::cmd_t cmd,
	input wire logic cmd_refused,
	input wire logic keyswitch,
	input wire logic power_event,
	input wire logic console_btn,
	input wire logic unimpl_instr,
	input wire logic monitor_call,
	input wire logic access_abort,
	input wire logic priv_abort,
	input wire pip_pkg::vec_t vec,
	input wire logic [15:0] enable_mask,
	input wire logic [15:0] request_mask,
	input wire logic [15:0] active_mask,
	input wire logic panel_ctrl_ok
);
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// A take is any edge at which a new active bit appears.
	sequence take_s;
		(active_mask & ~$past(active_mask)) != 16'h0000;
	endsequence
	sequence answer_s;
		##3 (vec.valid && active_mask[vec.level]);
	endsequence
	chk_vec_latency: assert property (take_s |-> answer_s)
		else $error("vector did not follow its take");
	chk_vec_pulse: assert property (vec.valid |=> !vec.valid)
		else $error("vector valid stood too long");
	chk_take_enabled: assert property ((active_mask &
		~$past(active_mask) & ~$past(enable_mask)) == 16'h0000)
		else $error("disabled level was taken");
	chk_abort_trap: assert property (access_abort |=> request_mask[2])
		else $error("access abort did not request level 2");
	chk_priv_trap: assert property (priv_abort |=> request_mask[2])
		else $error("privileged abort did not request level 2");
	chk_refused_inside: assert property (cmd_refused |->
		keyswitch && cmd.valid && priv_abort)
		else $error("command refused outside protection");
	chk_panel_lock: assert property (panel_ctrl_ok == !$past(keyswitch))
		else $error("panel control does not follow keyswitch");
	chk_power_req: assert property (power_event |=> request_mask[0])
		else $error("power event did not request level 0");
	chk_console_req: assert property ($rose(console_btn) |=>
		request_mask[14])
		else $error("console button did not request level e");
	chk_trap_unimpl: assert property ((unimpl_instr ||
		monitor_call) |=> request_mask[3])
		else $error("unimplemented trap did not request level 3");
endmodule : pip_monitor

bind priority_interrupt_protect pip_monitor i_mon (.clock, .rstn, .cmd,
	.cmd_refused, .keyswitch, .power_event, .console_btn, .unimpl_instr,
	.monitor_call, .access_abort, .priv_abort, .vec, .enable_mask,
	.request_mask, .active_mask, .panel_ctrl_ok);

/* File: tb/test_priority_interrupt_protect.sv */
// Self-checking bench of the priority interrupt and protect block.
`timescale 1ns/1ps
module test_priority_interrupt_protect;
	localparam int DIV = 16;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	pip_pkg::cmd_t cmd = '0;
	pip_pkg::acc_t mem_acc = '0;
	pip_pkg::vec_t vec, note;
	logic cpu_boundary = 1'b1, keyswitch = 1'b0, priv_instr = 1'b0;
	logic power_event = 1'b0, console_btn = 1'b0;
	logic unimpl_instr = 1'b0, monitor_call = 1'b0;
	logic ask = 1'b0, ask_end = 1'b0;
	logic [5:0] ask_dev = 6'h00, d, e;
	logic [15:0] cpu_pc = 16'h0000, s0, s1;
	logic [15:0] enable_mask, request_mask, active_mask, defer_mask;
	logic [63:0] pl_xfer_line, pl_end_line, xfer_connect, end_connect;
	logic cmd_ready, cmd_refused, access_abort, priv_abort, panel_ctrl_ok;
	logic [31:0] seed = 32'hd1b3;
	logic [15:0] ent [16];
	logic [3:0] src_lvl [4] = '{4'h0, 4'he, 4'h3, 4'h3};
	logic [15:0] acc_a [6] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200,
		16'h8000, 16'h7fff};
	logic [5:0] acc_ab = 6'h29;
	pip_pkg::vec_t exp_q [$];
	int failures = 0, checks = 0, cycles = 0, t0;

	always #2 clock = ~clock;

	priority_interrupt_protect #(.RTC_DIV(DIV)) i_dut (.clock, .rstn, .cmd,
		.cmd_ready, .cmd_refused, .cpu_boundary, .cpu_pc, .unimpl_instr,
		.monitor_call, .priv_instr, .power_event, .console_btn, .keyswitch,
		.mem_acc, .access_abort, .priv_abort, .pl_xfer_line, .pl_end_line,
		.xfer_connect, .end_connect, .vec, .enable_mask, .request_mask,
		.active_mask, .defer_mask, .panel_ctrl_ok);

	party_devices i_dev (.clock, .rstn, .ask, .ask_end, .ask_dev,
		.xfer_connect, .end_connect, .vec, .pl_xfer_line, .pl_end_line);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// The command is held until the edge at which it is taken.
	task automatic send(input pip_pkg::cmd_op_t op,
		input logic [3:0] lvl = 4'h0, input logic [7:0] addr = 8'h00,
		input logic [15:0] data = 16'h0000);
		int n;
		@(posedge clock);
		cmd <= '{1'b1, op, lvl, addr, data};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!(cmd_ready === 1'b1 && cmd_refused === 1'b0) && n < 50);
		cmd <= '0;
		if (n >= 50) chk("command taken", 1, 0);
	endtask : send

	task automatic expect_vec(input logic [3:0] lvl, input logic sv,
		input logic [5:0] sub, input logic [15:0] en);
		exp_q.push_back('{1'b1, lvl, sv, sub, en});
	endtask : expect_vec

	task automatic drain();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 300) begin
			@(posedge clock);
			n++;
		end
		chk("vectors outstanding", 0, exp_q.size());
	endtask : drain

	// Each vector pulse is matched against the oldest note.
	always @(posedge clock) begin
		if (rstn && vec.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected vector", 16'hffff, vec.level);
			end else begin
				note = exp_q.pop_front();
				chk("vector level", note.level, vec.level);
				chk("vector sub flag", note.sub_valid, vec.sub_valid);
				if (note.sub_valid) chk("vector sub", note.sub, vec.sub);
				chk("vector entry", note.entry, vec.entry);
			end
		end
	end

	// A hang is cut short well after the expected run length.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("FAIL run length expected finish seen hang");
			stop_test();
		end
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
		chk("reset masks", 64'h0, {enable_mask, request_mask, active_mask,
			defer_mask});
		chk("reset panel", 1, panel_ctrl_ok);
		for (int l = 0; l < 16; l++) begin
			ent[l] = 16'(xs());
			send(pip_pkg::OP_WRITE_VEC, 4'h0, 8'(2 * l), ent[l]);
		end
		// Pending levels wait while the processor is not at a boundary.
		@(posedge clock) cpu_boundary <= 1'b0;
		for (int l = 7; l < 10; l++) begin
			send(pip_pkg::OP_SET_EN, 4'(l));
			send(pip_pkg::OP_SET_REQ, 4'(l));
		end
		send(pip_pkg::OP_SET_REQ, 4'ha);
		send(pip_pkg::OP_SET_DEFER, 4'h7);
		#1;
		chk("defer mask", 16'h0080, defer_mask);
		chk("enable mask", 16'h0380, enable_mask);
		chk("request mask", 16'h0780, request_mask);
		// Lowest number first, preemption of 9 by 8, deferred 7 last.
		expect_vec(4'h8, 1'b0, 6'h00, ent[8]);
		@(posedge clock) cpu_boundary <= 1'b1;
		drain();
		send(pip_pkg::OP_RETURN);
		expect_vec(4'h9, 1'b0, 6'h00, ent[9]);
		drain();
		expect_vec(4'h8, 1'b0, 6'h00, ent[8]);
		send(pip_pkg::OP_SET_REQ, 4'h8);
		drain();
		send(pip_pkg::OP_RETURN);
		send(pip_pkg::OP_RETURN);
		expect_vec(4'h7, 1'b0, 6'h00, ent[7]);
		drain();
		send(pip_pkg::OP_RETURN);
		send(pip_pkg::OP_CLR_DEFER, 4'h7);
		#1;
		chk("defer cleared", 0, defer_mask);
		// Party lines with one connected device on each.
		d = 6'(xs());
		e = d ^ 6'h2a;
		s0 = 16'(xs());
		s1 = 16'(xs());
		send(pip_pkg::OP_CONNECT, 4'h4, 8'h00, {10'h000, d});
		send(pip_pkg::OP_CONNECT, 4'h5, 8'h00, {10'h000, e});
		#1;
		chk("xfer connect", 64'h1 << d, xfer_connect);
		chk("end connect", 64'h1 << e, end_connect);
		send(pip_pkg::OP_WRITE_VEC, 4'h0, 8'h20 + 8'(d), s0);
		send(pip_pkg::OP_WRITE_VEC, 4'h0, 8'h60 + 8'(e), s1);
		send(pip_pkg::OP_SET_EN, 4'h4);
		send(pip_pkg::OP_SET_EN, 4'h5);
		@(posedge clock) {ask, ask_end, ask_dev} <= {2'b10, d ^ 6'h01};
		@(posedge clock) ask <= 1'b0;
		repeat (8) @(posedge clock);
		#1;
		chk("unconnected device", 0, active_mask[4]);
		for (int k = 0; k < 2; k++) begin
			expect_vec(4'(4 + k), 1'b1, k ? e : d, k ? s1 : s0);
			@(posedge clock) {ask, ask_end, ask_dev} <= {1'b1, k[0], k ? e : d};
			@(posedge clock) ask <= 1'b0;
			drain();
			send(pip_pkg::OP_CLR_REQ, 4'(4 + k));
			send(pip_pkg::OP_RETURN);
		end
		send(pip_pkg::OP_DISCONNECT, 4'h4, 8'h00, {10'h000, d});
		#1;
		chk("xfer disconnect", 0, xfer_connect);
		// Power, console, unimplemented and monitor-call sources.
		for (int k = 0; k < 4; k++) begin
			send(pip_pkg::OP_SET_EN, src_lvl[k]);
		end
		for (int k = 0; k < 4; k++) begin
			expect_vec(src_lvl[k], 1'b0, 6'h00, ent[src_lvl[k]]);
			@(posedge clock)
			{power_event, console_btn, unimpl_instr, monitor_call} <= 4'h8 >> k;
			@(posedge clock)
			{power_event, console_btn, unimpl_instr, monitor_call} <= 4'h0;
			drain();
			send(pip_pkg::OP_RETURN);
		end
		// Protection with bounds at blocks 2 and 3, common from block 256.
		send(pip_pkg::OP_LOAD_LOWER, 4'h0, 8'h00, 16'h0002);
		send(pip_pkg::OP_LOAD_UPPER, 4'h0, 8'h00, 16'h0003);
		send(pip_pkg::OP_LOAD_COMMON, 4'h0, 8'h00, 16'h0100);
		@(posedge clock) {keyswitch, cpu_pc} <= {1'b1, 16'h0105};
		repeat (2) @(posedge clock);
		#1;
		chk("panel locked", 0, panel_ctrl_ok);
		for (int k = 0; k < 6; k++) begin
			@(posedge clock) mem_acc <= '{1'b1, ~k[0], k[0], acc_a[k]};
			#1;
			chk("access abort", acc_ab[k], access_abort);
		end
		@(posedge clock) {mem_acc, priv_instr} <= {19'h0, 1'b1};
		#1;
		chk("privileged abort", 1, priv_abort);
		@(posedge clock) priv_instr <= 1'b0;
		cmd <= '{1'b1, pip_pkg::OP_SET_EN, 4'hb, 8'h00, 16'h0000};
		#1;
		chk("command refused", 1, cmd_refused);
		@(posedge clock) cmd <= '0;
		@(posedge clock) keyswitch <= 1'b0;
		#1;
		chk("refused enable", 0, enable_mask[11]);
		chk("protect request", 1, request_mask[2]);
		send(pip_pkg::OP_CLR_REQ, 4'h2);
		send(pip_pkg::OP_CLR_REQ, 4'ha);
		#1;
		chk("requests cleared", 0, request_mask);
		// The real-time clock requests level 6 only while level 6 is enabled.
		expect_vec(4'h6, 1'b0, 6'h00, ent[6]);
		t0 = cycles;
		send(pip_pkg::OP_SET_EN, 4'h6);
		drain();
		chk("clock tick delay", 1, (cycles - t0) <= DIV + 8);
		send(pip_pkg::OP_CLR_EN, 4'h6);
		send(pip_pkg::OP_RETURN);
		repeat (3 * DIV) @(posedge clock);
		chk("clock off", 0, request_mask);
		stop_test();
	end
endmodule : test_priority_interrupt_protect
